// file: ds_spread_consts.vh
// Purpose: Constants for the forward-link direct-sequence spreader and scrambler.
// Assumes: One chip clock; symbol components are signed 8-bit values.
// Notes: Chip negation masks hold a one where the code chip is -1, chip 0 in bit 0.
`ifndef DS_SPREAD_CONSTS_VH
`define DS_SPREAD_CONSTS_VH

`define SYM_W 8
`define CHIP_W 9
`define LFSR_W 18
`define SEED_W 18
`define BUF_W_IN 18
`define BUF_W_OUT 20

// Scrambling sequence period in chips and register start values.
`define SCR_PERIOD 17'h10374
`define X_INIT 18'h00001
`define Y_INIT 18'h3ffff

// Chip pattern select codes.
`define PAT_SF2_PP 3'h0
`define PAT_SF2_PM 3'h1
`define PAT_SF3_PPP 3'h2
`define PAT_SF4_A 3'h3
`define PAT_SF4_B 3'h4
`define PAT_SF4_C 3'h5
`define PAT_SF4_D 3'h6
`define PAT_SF1 3'h7

// Spread factors.
`define SF_1 3'h1
`define SF_2 3'h2
`define SF_3 3'h3
`define SF_4 3'h4

// Negative-chip masks.
`define NEG_SF2_PP 4'h0
`define NEG_SF2_PM 4'h2
`define NEG_SF3_PPP 4'h0
`define NEG_SF4_A 4'h0
`define NEG_SF4_B 4'hc
`define NEG_SF4_C 4'ha
`define NEG_SF4_D 4'h6
`define NEG_SF1 4'h0

`endif

// file: two_entry_buffer.v
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: Output data, output valid and input ready all come from flip-flops.
`timescale 1ns/10ps
module two_entry_buffer #(
  parameter WIDTH = 8
) (
  input wire mclk_i,
  input wire rstn_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg head_v_q;
  reg skid_v_q;
  reg in_ready_q;
  reg [WIDTH-1:0] head_q;
  reg [WIDTH-1:0] skid_q;
  wire push;
  wire head_free;

  // A word is only taken while the spare entry is empty.
  assign push = in_valid_i & ~skid_v_q;
  assign head_free = ~head_v_q | out_ready_i;
  // Ready mirrors the empty spare entry from its own flip-flop.
  assign in_ready_o = in_ready_q;
  assign out_valid_o = head_v_q;
  assign out_data_o = head_q;

  always @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      head_v_q <= 1'b0;
      skid_v_q <= 1'b0;
      in_ready_q <= 1'b1;
      head_q <= {WIDTH{1'b0}};
      skid_q <= {WIDTH{1'b0}};
    end
    else if (head_free)
    begin
      if (skid_v_q)
      begin
        head_q <= skid_q;
        head_v_q <= 1'b1;
        skid_v_q <= 1'b0;
        in_ready_q <= 1'b1;
      end
      else
      begin
        head_q <= in_data_i;
        head_v_q <= push;
      end
    end
    else if (push)
    begin
      skid_q <= in_data_i;
      skid_v_q <= 1'b1;
      in_ready_q <= 1'b0;
    end
  end

endmodule // two_entry_buffer

// file: ds_spreader_scrambler.v
// Purpose: Spreads frame symbols by a real chip code and scrambles the chips.
// Assumes: Inputs synchronous to mclk_i; one chip may leave per clock.
// Notes: The seed index is advanced to its start state in the background.
`timescale 1ns/10ps
`include "ds_spread_consts.vh"

// What this block does
// - Every frame symbol, header and pilots, is spread.
// - Each symbol gives spread_factor chips per branch.
// - Code restarts at chip zero each symbol.
// - Chip i uses symbol i/sf, code i mod sf.
// - Chip rate is spread_factor times symbol rate.
// - Factor one equals the plain unspread waveform.
// - Spreading feeds scrambling with nothing between.
// - Scrambling runs over all spread frame chips.
// - Header and pilot chips are scrambled too.
// - Scrambler restarts at every frame start.
// - Chip i uses sequence element i mod 66420.
// - Chips multiply the complex scrambling code.
// - Codes 000, 001, 010, 111 select small factors.
// - Codes 011 to 110 select factor four.
// - Chips then go to an external pulse shaper.
module ds_spreader_scrambler (
  input wire mclk_i,
  input wire rstn_i,
  input wire [2:0] chip_pattern_select_i,
  input wire [`SEED_W-1:0] scram_seed_number_i,
  input wire sym_valid_i,
  output wire sym_ready_o,
  input wire sym_sof_i,
  input wire sym_eof_i,
  input wire [`SYM_W-1:0] sym_re_i,
  input wire [`SYM_W-1:0] sym_im_i,
  output wire chip_valid_o,
  input wire chip_ready_i,
  output wire chip_sof_o,
  output wire chip_eof_o,
  output wire [`CHIP_W-1:0] chip_re_o,
  output wire [`CHIP_W-1:0] chip_im_o,
  output wire [2:0] spread_factor_o,
  output wire seed_busy_o
);

  localparam ENG_IDLE = 2'b01;
  localparam ENG_RUN = 2'b10;

  // Input side buffer.
  wire ib_valid;
  wire [`BUF_W_IN-1:0] ib_data;
  wire ib_sof;
  wire ib_eof;
  wire ib_ready;

  // Symbol being spread.
  reg hold_v_q;
  reg hold_sof_q;
  reg hold_eof_q;
  reg [`SYM_W-1:0] hold_re_q;
  reg [`SYM_W-1:0] hold_im_q;
  reg [1:0] cidx_q;
  reg [2:0] pat_q;
  reg [2:0] sf_out_q;

  // Scrambler state.
  reg [`LFSR_W-1:0] x_q;
  reg [`LFSR_W-1:0] y_q;
  reg [`LFSR_W-1:0] seed_x_q;
  reg [16:0] scr_cnt_q;

  // Seed advance engine.
  reg [1:0] eng_state_q;
  reg [`SEED_W-1:0] eng_tgt_q;
  reg [`SEED_W-1:0] eng_cnt_q;
  reg [`LFSR_W-1:0] eng_x_q;

  wire [2:0] sf_w;
  wire [3:0] neg_w;
  wire last_chip;
  wire frame_first;
  wire seed_stale;
  wire ob_ready;
  wire emit;
  wire load;
  wire wrap;
  wire [`LFSR_W-1:0] x_cur;
  wire [`LFSR_W-1:0] y_cur;
  wire z1;
  wire z2;
  wire [1:0] rot;
  wire [`CHIP_W-1:0] ext_re;
  wire [`CHIP_W-1:0] ext_im;
  wire [`CHIP_W-1:0] s_re;
  wire [`CHIP_W-1:0] s_im;
  reg [`CHIP_W-1:0] z_re;
  reg [`CHIP_W-1:0] z_im;
  wire [`BUF_W_OUT-1:0] ob_data_in;
  wire [`BUF_W_OUT-1:0] ob_data;

  function [2:0] sf_of;
    input [2:0] pat;
    begin
      case (pat)
        `PAT_SF2_PP: sf_of = `SF_2;
        `PAT_SF2_PM: sf_of = `SF_2;
        `PAT_SF3_PPP: sf_of = `SF_3;
        `PAT_SF1: sf_of = `SF_1;
        default: sf_of = `SF_4;
      endcase
    end
  endfunction

  function [3:0] neg_of;
    input [2:0] pat;
    begin
      case (pat)
        `PAT_SF2_PP: neg_of = `NEG_SF2_PP;
        `PAT_SF2_PM: neg_of = `NEG_SF2_PM;
        `PAT_SF3_PPP: neg_of = `NEG_SF3_PPP;
        `PAT_SF4_A: neg_of = `NEG_SF4_A;
        `PAT_SF4_B: neg_of = `NEG_SF4_B;
        `PAT_SF4_C: neg_of = `NEG_SF4_C;
        `PAT_SF4_D: neg_of = `NEG_SF4_D;
        default: neg_of = `NEG_SF1;
      endcase
    end
  endfunction

  function [`LFSR_W-1:0] step_x;
    input [`LFSR_W-1:0] x;
    begin
      step_x = {x[0] ^ x[7], x[17:1]};
    end
  endfunction

  function [`LFSR_W-1:0] step_y;
    input [`LFSR_W-1:0] y;
    begin
      step_y = {y[0] ^ y[5] ^ y[7] ^ y[10], y[17:1]};
    end
  endfunction

  two_entry_buffer #(
    .WIDTH(`BUF_W_IN)
  ) u_in_buf (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .in_valid_i(sym_valid_i),
    .in_ready_o(sym_ready_o),
    .in_data_i({sym_sof_i, sym_eof_i, sym_re_i, sym_im_i}),
    .out_valid_o(ib_valid),
    .out_ready_i(ib_ready),
    .out_data_o(ib_data)
  );

  assign ib_sof = ib_data[17];
  assign ib_eof = ib_data[16];

  assign sf_w = sf_of(pat_q);
  assign neg_w = neg_of(pat_q);

  assign last_chip = ({1'b0, cidx_q} == (sf_w - 3'h1));
  assign frame_first = hold_sof_q & (cidx_q == 2'h0);
  assign seed_stale = (eng_state_q != ENG_IDLE) | (eng_tgt_q != scram_seed_number_i);
  assign emit = hold_v_q & ob_ready & ~(frame_first & seed_stale);
  assign load = ib_valid & (~hold_v_q | (emit & last_chip));
  assign ib_ready = load;

  assign ext_re = {hold_re_q[`SYM_W-1], hold_re_q};
  assign ext_im = {hold_im_q[`SYM_W-1], hold_im_q};
  assign s_re = neg_w[cidx_q] ? (~ext_re + 9'h001) : ext_re;
  assign s_im = neg_w[cidx_q] ? (~ext_im + 9'h001) : ext_im;

  assign wrap = (scr_cnt_q == `SCR_PERIOD);
  assign x_cur = frame_first ? eng_x_q : (wrap ? seed_x_q : x_q);
  assign y_cur = (frame_first | wrap) ? `Y_INIT : y_q;

  assign z1 = x_cur[0] ^ y_cur[0];
  assign z2 = x_cur[4] ^ x_cur[6] ^ x_cur[15] ^ y_cur[5] ^ y_cur[6] ^ (^y_cur[15:8]);
  assign rot = {z2, z1};

  always @*
  begin
    case (rot)
      2'h1:
      begin
        z_re = ~s_im + 9'h001;
        z_im = s_re;
      end
      2'h2:
      begin
        z_re = ~s_re + 9'h001;
        z_im = ~s_im + 9'h001;
      end
      2'h3:
      begin
        z_re = s_im;
        z_im = ~s_re + 9'h001;
      end
      default:
      begin
        z_re = s_re;
        z_im = s_im;
      end
    endcase
  end

  assign ob_data_in = {frame_first, hold_eof_q & last_chip, z_re, z_im};

  two_entry_buffer #(
    .WIDTH(`BUF_W_OUT)
  ) u_out_buf (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .in_valid_i(emit),
    .in_ready_o(ob_ready),
    .in_data_i(ob_data_in),
    .out_valid_o(chip_valid_o),
    .out_ready_i(chip_ready_i),
    .out_data_o(ob_data)
  );

  assign chip_sof_o = ob_data[19];
  assign chip_eof_o = ob_data[18];
  assign chip_re_o = ob_data[17:9];
  assign chip_im_o = ob_data[8:0];
  assign spread_factor_o = sf_out_q;
  assign seed_busy_o = eng_state_q[1];

  always @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hold_v_q <= 1'b0;
      hold_sof_q <= 1'b0;
      hold_eof_q <= 1'b0;
      hold_re_q <= 8'h00;
      hold_im_q <= 8'h00;
      cidx_q <= 2'h0;
      pat_q <= `PAT_SF1;
      sf_out_q <= `SF_1;
    end
    else
    begin
      if (load)
      begin
        hold_v_q <= 1'b1;
        hold_sof_q <= ib_sof;
        hold_eof_q <= ib_eof;
        hold_re_q <= ib_data[15:8];
        hold_im_q <= ib_data[7:0];
        cidx_q <= 2'h0;
        if (ib_sof)
        begin
          pat_q <= chip_pattern_select_i;
          sf_out_q <= sf_of(chip_pattern_select_i);
        end
      end
      else if (emit)
      begin
        if (last_chip)
        begin
          hold_v_q <= 1'b0;
          cidx_q <= 2'h0;
        end
        else
        begin
          cidx_q <= cidx_q + 2'h1;
        end
      end
    end
  end

  always @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      x_q <= `X_INIT;
      y_q <= `Y_INIT;
      seed_x_q <= `X_INIT;
      scr_cnt_q <= 17'h00000;
    end
    else if (emit)
    begin
      x_q <= step_x(x_cur);
      y_q <= step_y(y_cur);
      if (frame_first | wrap)
      begin
        scr_cnt_q <= 17'h00001;
      end
      else
      begin
        scr_cnt_q <= scr_cnt_q + 17'h00001;
      end
      if (frame_first)
      begin
        seed_x_q <= eng_x_q;
      end
    end
  end

  always @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      eng_state_q <= ENG_IDLE;
      eng_tgt_q <= 18'h00000;
      eng_cnt_q <= 18'h00000;
      eng_x_q <= `X_INIT;
    end
    else
    begin
      case (eng_state_q)
        ENG_IDLE:
        begin
          if (eng_tgt_q != scram_seed_number_i)
          begin
            eng_tgt_q <= scram_seed_number_i;
            eng_cnt_q <= scram_seed_number_i;
            eng_x_q <= `X_INIT;
            if (scram_seed_number_i != 18'h00000)
            begin
              eng_state_q <= ENG_RUN;
            end
          end
        end
        ENG_RUN:
        begin
          eng_x_q <= step_x(eng_x_q);
          eng_cnt_q <= eng_cnt_q - 18'h00001;
          if (eng_cnt_q == 18'h00001)
          begin
            eng_state_q <= ENG_IDLE;
          end
        end
        default:
        begin
          eng_state_q <= ENG_IDLE;
        end
      endcase
    end
  end

endmodule // ds_spreader_scrambler

// file: ds_spread_monitor.sv
// Purpose: Port checks for the spreader and scrambler.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Attached to the top module by the bind below.
`timescale 1ns/10ps
module ds_spread_monitor (
  input wire mclk_i,
  input wire rstn_i,
  input wire sym_ready_o,
  input wire chip_valid_o,
  input wire chip_ready_i,
  input wire chip_sof_o,
  input wire chip_eof_o,
  input wire [8:0] chip_re_o,
  input wire [8:0] chip_im_o,
  input wire [2:0] spread_factor_o,
  input wire seed_busy_o
);
  reg [17:0] cnt_q;
  reg [2:0] sf_q;
  reg done_q;
  wire take = chip_valid_o && chip_ready_i;
  always @(posedge mclk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      cnt_q <= 18'h0;
      sf_q <= 3'h1;
      done_q <= 1'b1;
    end
    else if (take)
    begin
      cnt_q <= chip_sof_o ? 18'h1 : cnt_q + 18'h1;
      sf_q <= chip_sof_o ? spread_factor_o : sf_q;
      done_q <= chip_eof_o;
    end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  a_valid_held: assert property (chip_valid_o && !chip_ready_i |=> chip_valid_o)
    else $error("chip valid dropped untaken");
  a_data_held: assert property (chip_valid_o && !chip_ready_i |=> $stable({chip_re_o, chip_im_o, chip_sof_o}))
    else $error("chip changed untaken");
  a_factor_legal: assert property (spread_factor_o >= 3'h1 && spread_factor_o <= 3'h4)
    else $error("bad spread factor");
  a_reset_idle: assert property (disable iff (1'b0) !rstn_i |-> !chip_valid_o && sym_ready_o
    && spread_factor_o == 3'h1 && !seed_busy_o)
    else $error("outputs not idle in reset");
  a_re_range: assert property (chip_valid_o |-> $signed(chip_re_o) >= -128 && $signed(chip_re_o) <= 128)
    else $error("chip re out of range");
  a_im_range: assert property (chip_valid_o |-> $signed(chip_im_o) >= -128 && $signed(chip_im_o) <= 128)
    else $error("chip im out of range");
  a_sof_first: assert property (take && done_q |-> chip_sof_o)
    else $error("frame lacks start chip");
  a_frame_whole: assert property (take && chip_eof_o && !chip_sof_o |-> (cnt_q + 18'h1) % sf_q == 18'h0)
    else $error("frame not whole symbols");
  cover property (take && chip_sof_o && spread_factor_o == 3'h4);
  cover property (chip_valid_o && !chip_ready_i ##1 chip_valid_o && !chip_ready_i);
  cover property ($rose(seed_busy_o));
  cover property ($fell(sym_ready_o));
endmodule // ds_spread_monitor

bind ds_spreader_scrambler ds_spread_monitor mon (.mclk_i(mclk_i), .rstn_i(rstn_i), .sym_ready_o(sym_ready_o),
  .chip_valid_o(chip_valid_o), .chip_ready_i(chip_ready_i), .chip_sof_o(chip_sof_o), .chip_eof_o(chip_eof_o),
  .chip_re_o(chip_re_o), .chip_im_o(chip_im_o), .spread_factor_o(spread_factor_o), .seed_busy_o(seed_busy_o));

// file: chip_sink.sv
// Purpose: Downstream pulse-shaper stand-in that takes chips.
// Assumes: Runs from the bench clock and reset.
// Notes: With stall_i high it refuses four cycles in eight.
`timescale 1ns/10ps
module chip_sink (
  input wire mclk_i,
  input wire rstn_i,
  input wire stall_i,
  output reg chip_ready_o
);
  reg [2:0] ph_q;
  always @(posedge mclk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      ph_q <= 3'h0;
      chip_ready_o <= 1'b0;
    end
    else
    begin
      ph_q <= ph_q + 3'h1;
      chip_ready_o <= #1 !stall_i || ph_q[2];
    end
endmodule // chip_sink

// file: ds_spreader_scrambler_bench.sv
// Purpose: Self-checking bench for the spreader and scrambler.
// Assumes: Seed n starts x at one stepped n times, y at all ones.
// Notes: Rows hold pattern, seed, symbol base, factor and negative-chip mask.
`timescale 1ns/10ps
module ds_spreader_scrambler_bench;
  reg mclk_i = 0, rstn_i = 1, sym_valid_i = 0, sym_sof_i = 0, sym_eof_i = 0, stall = 0;
  reg [2:0] pat = 3'h7;
  reg [17:0] seed = 18'h0;
  reg [7:0] sre = 8'h0, sim = 8'h0;
  wire sym_ready_o, chip_valid_o, chip_ready_i, chip_sof_o, chip_eof_o, seed_busy_o;
  wire [8:0] chip_re_o, chip_im_o;
  wire [2:0] spread_factor_o;
  reg [29:0] rows [0:8];
  reg [7:0] tre [0:3];
  reg [7:0] tim [0:3];
  reg [17:0] x, y, x0;
  reg [8:0] a, b, ea, eb;
  reg [2:0] sf;
  reg [3:0] ng;
  integer mismatches = 0, checks_done = 0, r, k, t, i, n, m, ns;
  always #10 mclk_i = ~mclk_i;
  chip_sink sink (.mclk_i(mclk_i), .rstn_i(rstn_i), .stall_i(stall), .chip_ready_o(chip_ready_i));
  ds_spreader_scrambler dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .chip_pattern_select_i(pat),
    .scram_seed_number_i(seed), .sym_valid_i(sym_valid_i), .sym_ready_o(sym_ready_o), .sym_sof_i(sym_sof_i),
    .sym_eof_i(sym_eof_i), .sym_re_i(sre), .sym_im_i(sim), .chip_valid_o(chip_valid_o),
    .chip_ready_i(chip_ready_i), .chip_sof_o(chip_sof_o), .chip_eof_o(chip_eof_o), .chip_re_o(chip_re_o),
    .chip_im_o(chip_im_o), .spread_factor_o(spread_factor_o), .seed_busy_o(seed_busy_o));
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
        mismatches = mismatches + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task give_up;
    begin
      mismatches = mismatches + 1;
      tally_and_finish;
    end
  endtask
  task frame(input [29:0] w);
    begin
      pat = w[29:27];
      seed = {14'h0, w[26:23]};
      sf = w[6:4];
      ng = w[3:0];
      x = 18'h1;
      y = 18'h3ffff;
      for (k = 0; k < w[26:23]; k = k + 1)
        x = {x[0] ^ x[7], x[17:1]};
      x0 = x;
      for (k = 0; k < 4; k = k + 1)
      begin
        tre[k] = w[22:15] ^ k[7:0];
        tim[k] = w[14:7] + k[7:0];
      end
      fork
        begin
          @(posedge mclk_i);
          #1;
          for (t = 0; t < ns; t = t + 1)
          begin
            sym_valid_i = 1'b1;
            sym_sof_i = (t == 0);
            sym_eof_i = (t == ns - 1);
            sre = tre[t % 4];
            sim = tim[t % 4];
            n = 0;
            @(negedge mclk_i);
            while (!sym_ready_o && n < 500)
            begin
              n = n + 1;
              @(negedge mclk_i);
            end
            if (n == 500)
              give_up;
            @(posedge mclk_i);
            #1;
          end
          sym_valid_i = 1'b0;
        end
        begin
          for (i = 0; i < ns * sf; i = i + 1)
          begin
            m = 0;
            @(negedge mclk_i);
            while (!(chip_valid_o && chip_ready_i) && m < 500)
            begin
              m = m + 1;
              @(negedge mclk_i);
            end
            if (m == 500)
              give_up;
            a = {tre[(i / sf) % 4][7], tre[(i / sf) % 4]};
            b = {tim[(i / sf) % 4][7], tim[(i / sf) % 4]};
            if (ng[i % sf])
            begin
              a = -a;
              b = -b;
            end
            case ({x[4] ^ x[6] ^ x[15] ^ y[5] ^ y[6] ^ (^y[15:8]), x[0] ^ y[0]})
              2'h0: {ea, eb} = {a, b};
              2'h1: {ea, eb} = {-b, a};
              2'h2: {ea, eb} = {-a, -b};
              default: {ea, eb} = {b, -a};
            endcase
            chk({chip_sof_o, chip_eof_o, spread_factor_o, chip_re_o, chip_im_o},
              {i == 0, i == ns * sf - 1, sf, ea, eb});
            if (i == 0)
            begin
              @(posedge mclk_i);
              #1;
              pat = ~pat;
            end
            x = {x[0] ^ x[7], x[17:1]};
            y = {y[0] ^ y[5] ^ y[7] ^ y[10], y[17:1]};
            if ((i + 1) % 66420 == 0)
            begin
              x = x0;
              y = 18'h3ffff;
            end
          end
        end
      join
      @(posedge mclk_i);
      #1;
    end
  endtask
  initial
  begin
    rows[0] = {3'h0, 4'h0, 8'h15, 8'hf3, 3'h2, 4'h0};
    rows[1] = {3'h1, 4'h0, 8'h7f, 8'h81, 3'h2, 4'h2};
    rows[2] = {3'h2, 4'h0, 8'hc4, 8'h3a, 3'h3, 4'h0};
    rows[3] = {3'h3, 4'h0, 8'h27, 8'h99, 3'h4, 4'h0};
    rows[4] = {3'h4, 4'h0, 8'he0, 8'h1f, 3'h4, 4'hc};
    rows[5] = {3'h5, 4'h0, 8'h5a, 8'ha5, 3'h4, 4'ha};
    rows[6] = {3'h6, 4'h0, 8'h0c, 8'hd2, 3'h4, 4'h6};
    rows[7] = {3'h7, 4'h0, 8'h40, 8'hbf, 3'h1, 4'h0};
    rows[8] = {3'h7, 4'h3, 8'h80, 8'h7f, 3'h1, 4'h0};
    #1;
    rstn_i = 1'b0;
    repeat (20) @(posedge mclk_i);
    #1;
    chk({chip_valid_o, sym_ready_o, spread_factor_o, seed_busy_o}, 32'h12);
    rstn_i = 1'b1;
    ns = 3;
    for (r = 0; r < 9; r = r + 1)
    begin
      stall = r[0];
      frame(rows[r]);
    end
    @(posedge mclk_i);
    #1;
    rstn_i = 1'b0;
    @(posedge mclk_i);
    #1;
    chk({chip_valid_o, sym_ready_o, spread_factor_o, seed_busy_o}, 32'h12);
    rstn_i = 1'b1;
    ns = 1;
    frame(rows[7]);
    ns = 16606;
    stall = 1'b0;
    frame(rows[4]);
    tally_and_finish;
  end
endmodule // ds_spreader_scrambler_bench
